// [afctl_pkg.sv]
// Package for the asynchronous FIFO host controller.
// Assumes a 100 MHz system clock; strobe timing is expressed in cycles of it.
package afctl_pkg;
    localparam int WORD_WIDTH = 9;
    localparam int FIFO_DEPTH = 512;
    localparam int CLK_PERIOD_NS = 10;
    // Minimum strobe low, strobe high and access times in ns.
    localparam int STROBE_LOW_NS = 80;
    localparam int STROBE_HIGH_NS = 30;
    localparam int ACCESS_NS = 80;
    localparam int RESET_LOW_NS = 100;
    localparam int RETX_LOW_NS = 80;
    localparam int RECOVER_NS = 20;
    localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_LOW_CYC = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RETX_LOW_CYC = (RETX_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_WIDTH = 8;
    localparam int PUSH_CNT_WIDTH = 10;
    localparam logic [PUSH_CNT_WIDTH-1:0] RETX_PUSH_LIMIT = 10'h200;
    localparam logic [CNT_WIDTH-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_WIDTH-1:0] CNT_ONE = 8'h01;

    typedef enum logic [6:0] {
        AFCTL_RESET  = 7'b000_0001,
        AFCTL_IDLE   = 7'b000_0010,
        AFCTL_WLOW   = 7'b000_0100,
        AFCTL_RLOW   = 7'b000_1000,
        AFCTL_RTLOW  = 7'b001_0000,
        AFCTL_RECOV  = 7'b010_0000,
        AFCTL_WHOLD  = 7'b100_0000
    } afctl_state_type;

    function automatic logic [CNT_WIDTH-1:0] afctl_cyc(input int cycles);
        afctl_cyc = (cycles < 1) ? CNT_ONE : CNT_WIDTH'(cycles);
    endfunction
endpackage

// [afctl_buf_if.sv]
// Carrier between the controller and its two-entry read buffer.
// Assumes both ends share the controller clock.
`timescale 1ns/1ps
interface afctl_buf_if;
    import afctl_pkg::*;
    logic                  in_valid;
    logic                  in_ready;
    logic [WORD_WIDTH-1:0] in_data;
    logic                  out_valid;
    logic                  out_ready;
    logic [WORD_WIDTH-1:0] out_data;
    modport fill (output in_valid, output in_data, input in_ready);
    modport buffer (input in_valid, input in_data, output in_ready,
                    output out_valid, output out_data, input out_ready);
endinterface

// [afctl_skid.sv]
// Two-entry buffer for words read from the FIFO device.
// Assumes one clock; the drain side may stall at any time.
`timescale 1ns/1ps
module afctl_skid
    import afctl_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rstn,
    afctl_buf_if.buffer bus
);
    logic [WORD_WIDTH-1:0] store [2];
    logic                  head;
    logic                  tail;
    logic [1:0]            count;
    logic                  next_head;
    logic                  next_tail;
    logic [1:0]            next_count;
    logic                  push;
    logic                  pop;

    always_comb
    begin
        push = bus.in_valid && (count != 2'h2);
        pop = (count != 2'h0) && bus.out_ready;
        next_head = pop ? ~head : head;
        next_tail = push ? ~tail : tail;
        next_count = count + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            head <= 1'b0;
            tail <= 1'b0;
            count <= 2'h0;
        end
        else
        begin
            head <= next_head;
            tail <= next_tail;
            count <= next_count;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            store[tail] <= bus.in_data;
        end
    end

    assign bus.in_ready = (count != 2'h2);
    assign bus.out_valid = (count != 2'h0);
    assign bus.out_data = store[head];
endmodule

// [afctl_top.sv]
// Host controller that drives an asynchronous 512 x 9 FIFO through its pins.
// Assumes the device pins are synchronous to clk_sys and the device is alone
// on its bus (single mode); the user side is a plain valid/ready port list.
`timescale 1ns/1ps
module afctl_top
    import afctl_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  rstn,
    input  wire logic                  wr_valid,
    output logic                       wr_ready,
    input  wire logic [WORD_WIDTH-1:0] wr_data,
    output logic                       rd_valid,
    input  wire logic                  rd_ready,
    output logic [WORD_WIDTH-1:0]      rd_data,
    input  wire logic                  retx_req,
    output logic                       retx_ack,
    output logic                       retx_refused,
    output logic                       fifo_empty,
    output logic                       fifo_full,
    output logic                       fifo_half,
    output logic                       push_n,
    output logic                       pop_n,
    output logic [WORD_WIDTH-1:0]      data_to_fifo,
    input  wire logic [WORD_WIDTH-1:0] data_from_fifo,
    input  wire logic                  empty_flag_n,
    input  wire logic                  full_flag_n,
    input  wire logic                  half_full_flag_n,
    output logic                       retransmit_n,
    output logic                       expand_in_n,
    output logic                       reset_pin_n
);
    afctl_buf_if rdbuf ();

    afctl_skid u_skid (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .bus     (rdbuf.buffer)
    );

    afctl_state_type       state;
    afctl_state_type       next_state;
    logic [CNT_WIDTH-1:0]  cnt;
    logic [CNT_WIDTH-1:0]  next_cnt;
    logic [PUSH_CNT_WIDTH-1:0] pushes;
    logic [PUSH_CNT_WIDTH-1:0] next_pushes;
    logic                  next_push_n;
    logic                  next_pop_n;
    logic                  next_retransmit_n;
    logic                  next_reset_pin_n;
    logic [WORD_WIDTH-1:0] next_data_to_fifo;
    logic                  next_wr_ready;
    logic                  next_retx_ack;
    logic                  next_retx_refused;
    logic                  cap_valid;
    logic                  next_cap_valid;
    logic [WORD_WIDTH-1:0] cap_data;
    logic [WORD_WIDTH-1:0] next_cap_data;
    logic                  cnt_done;

    assign cnt_done = (cnt == CNT_ZERO);
    assign rdbuf.in_valid = cap_valid;
    assign rdbuf.in_data = cap_data;
    // The buffer gives up its head exactly when the output stage loads it, so no word repeats.
    assign rdbuf.out_ready = !rd_valid;

    always_comb
    begin
        next_state = state;
        next_cnt = cnt_done ? cnt : cnt - CNT_ONE;
        next_pushes = pushes;
        next_push_n = push_n;
        next_pop_n = pop_n;
        next_retransmit_n = 1'b1;
        next_reset_pin_n = 1'b1;
        next_data_to_fifo = data_to_fifo;
        next_wr_ready = 1'b0;
        next_retx_ack = 1'b0;
        next_retx_refused = 1'b0;
        next_cap_valid = cap_valid && !rdbuf.in_ready;
        next_cap_data = cap_data;
        case (state)
            AFCTL_RESET:
            begin
                next_reset_pin_n = 1'b0;
                next_push_n = 1'b1;
                next_pop_n = 1'b1;
                next_pushes = '0;
                if (cnt_done)
                begin
                    next_reset_pin_n = 1'b1;
                    next_state = AFCTL_RECOV;
                    next_cnt = afctl_cyc(RECOVER_CYC);
                end
            end
            AFCTL_IDLE:
            begin
                if (cnt_done)
                begin
                    if (retx_req)
                    begin
                        if (pushes > RETX_PUSH_LIMIT)
                        begin
                            next_retx_refused = 1'b1;
                        end
                        else
                        begin
                            next_retransmit_n = 1'b0;
                            next_state = AFCTL_RTLOW;
                            next_cnt = afctl_cyc(RETX_LOW_CYC);
                        end
                    end
                    else if (empty_flag_n && !cap_valid && rdbuf.in_ready)
                    begin
                        next_pop_n = 1'b0;
                        next_state = AFCTL_RLOW;
                        next_cnt = afctl_cyc(ACCESS_CYC);
                    end
                    else if (wr_valid && full_flag_n)
                    begin
                        next_push_n = 1'b0;
                        next_data_to_fifo = wr_data;
                        next_wr_ready = 1'b1;
                        next_state = AFCTL_WLOW;
                        next_cnt = afctl_cyc(STROBE_LOW_CYC);
                    end
                end
            end
            AFCTL_WLOW:
            begin
                if (cnt_done)
                begin
                    next_push_n = 1'b1;
                    if (pushes <= RETX_PUSH_LIMIT)
                    begin
                        next_pushes = pushes + 1'b1;
                    end
                    next_state = AFCTL_WHOLD;
                    next_cnt = afctl_cyc(STROBE_HIGH_CYC);
                end
            end
            AFCTL_RLOW:
            begin
                if (cnt_done)
                begin
                    next_cap_valid = 1'b1;
                    next_cap_data = data_from_fifo;
                    next_pop_n = 1'b1;
                    next_state = AFCTL_WHOLD;
                    next_cnt = afctl_cyc(STROBE_HIGH_CYC);
                end
            end
            AFCTL_RTLOW:
            begin
                next_retransmit_n = 1'b0;
                if (cnt_done)
                begin
                    next_retransmit_n = 1'b1;
                    next_retx_ack = 1'b1;
                    next_state = AFCTL_RECOV;
                    next_cnt = afctl_cyc(RECOVER_CYC);
                end
            end
            AFCTL_RECOV, AFCTL_WHOLD:
            begin
                if (cnt_done)
                begin
                    next_state = AFCTL_IDLE;
                end
            end
            default:
            begin
                next_state = AFCTL_RESET;
                next_cnt = afctl_cyc(RESET_LOW_CYC);
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= AFCTL_RESET;
            cnt <= CNT_WIDTH'(RESET_LOW_CYC);
            pushes <= 10'h000;
            push_n <= 1'b1;
            pop_n <= 1'b1;
            retransmit_n <= 1'b1;
            reset_pin_n <= 1'b0;
            data_to_fifo <= 9'h000;
            wr_ready <= 1'b0;
            retx_ack <= 1'b0;
            retx_refused <= 1'b0;
            cap_valid <= 1'b0;
            cap_data <= 9'h000;
            rd_valid <= 1'b0;
            rd_data <= 9'h000;
            fifo_empty <= 1'b1;
            fifo_full <= 1'b0;
            fifo_half <= 1'b0;
            expand_in_n <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            pushes <= next_pushes;
            push_n <= next_push_n;
            pop_n <= next_pop_n;
            retransmit_n <= next_retransmit_n;
            reset_pin_n <= next_reset_pin_n;
            data_to_fifo <= next_data_to_fifo;
            wr_ready <= next_wr_ready;
            retx_ack <= next_retx_ack;
            retx_refused <= next_retx_refused;
            cap_valid <= next_cap_valid;
            cap_data <= next_cap_data;
            // Output stage drains the buffer one word at a time.
            if (rd_valid && rd_ready)
            begin
                rd_valid <= 1'b0;
            end
            else if (!rd_valid && rdbuf.out_valid)
            begin
                rd_valid <= 1'b1;
                rd_data <= rdbuf.out_data;
            end
            fifo_empty <= !empty_flag_n;
            fifo_full <= !full_flag_n;
            fifo_half <= !half_full_flag_n;
            expand_in_n <= 1'b0;
        end
    end
endmodule

// [afctl_props.sv]
// Checker for the device-side strobes of the FIFO host controller.
// Assumes it is bound to afctl_top and sees only that module's ports.
`timescale 1ns/1ps
module afctl_props
    import afctl_pkg::*;
(
    input wire logic                  clk_sys,
    input wire logic                  rstn,
    input wire logic                  wr_ready,
    input wire logic [WORD_WIDTH-1:0] wr_data,
    input wire logic                  rd_valid,
    input wire logic                  rd_ready,
    input wire logic [WORD_WIDTH-1:0] rd_data,
    input wire logic                  retx_ack,
    input wire logic                  push_n,
    input wire logic                  pop_n,
    input wire logic [WORD_WIDTH-1:0] data_to_fifo,
    input wire logic                  empty_flag_n,
    input wire logic                  full_flag_n,
    input wire logic                  retransmit_n,
    input wire logic                  expand_in_n,
    input wire logic                  reset_pin_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    property p_pop_gate;
        $fell(pop_n) |-> $past(empty_flag_n);
    endproperty
    a_pop_gate: assert property (p_pop_gate) else $error("pop while empty");
    property p_push_gate;
        $fell(push_n) |-> $past(full_flag_n);
    endproperty
    a_push_gate: assert property (p_push_gate) else $error("push while full");
    property p_pop_width;
        $fell(pop_n) |-> ##8 !pop_n ##1 pop_n;
    endproperty
    a_pop_width: assert property (p_pop_width) else $error("pop width wrong");
    property p_retx_quiet;
        !retransmit_n |-> push_n && pop_n;
    endproperty
    a_retx_quiet: assert property (p_retx_quiet) else $error("strobe in rewind");
    property p_retx_done;
        $fell(retransmit_n) |-> ##9 (retransmit_n && retx_ack);
    endproperty
    a_retx_done: assert property (p_retx_done) else $error("rewind pulse wrong");
    property p_single_mode;
        $rose(reset_pin_n) |-> !expand_in_n && push_n && pop_n;
    endproperty
    a_single_mode: assert property (p_single_mode) else $error("bad reset exit");
    property p_push_data;
        wr_ready |-> $fell(push_n) && data_to_fifo == $past(wr_data);
    endproperty
    a_push_data: assert property (p_push_data) else $error("push word wrong");
    property p_rd_hold;
        rd_valid && !rd_ready |=> rd_valid && $stable(rd_data);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read word lost");
endmodule
bind afctl_top afctl_props u_props (.*);

// [afctl_dev_model.sv]
// Behavioural 512 x 9 FIFO device on the controller's pins.
// Assumes pins change only after clk_sys edges; strobes are seen per cycle.
`timescale 1ns/1ps
module afctl_dev_model
    import afctl_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  push_n,
    input  wire logic                  pop_n,
    input  wire logic                  retransmit_n,
    input  wire logic                  expand_in_n,
    input  wire logic                  reset_pin_n,
    input  wire logic [WORD_WIDTH-1:0] data_to_fifo,
    output logic      [WORD_WIDTH-1:0] data_from_fifo,
    output logic                       empty_flag_n,
    output logic                       full_flag_n,
    output logic                       half_full_flag_n
);
    logic [WORD_WIDTH-1:0] mem [FIFO_DEPTH];
    logic [8:0]            wptr, rptr;
    logic                  last_push, last_pop, last_retx, expanded;
    logic                  pop_wait, push_wait, edge_out, rd_turn;
    int                    count, pushes, level;
    // a push held low on a full buffer reasserts full at once
    assign empty_flag_n = (count != 0);
    assign full_flag_n = (count < FIFO_DEPTH - (push_wait ? 1 : 0));
    // half pin becomes expansion out when expanded
    assign half_full_flag_n = expanded ? edge_out : !(count > FIFO_DEPTH / 2);
    always @(posedge clk_sys)
    begin
        last_push <= push_n;
        last_pop <= pop_n;
        last_retx <= retransmit_n;
        edge_out <= 1'b1;
        if (pop_n)
            pop_wait <= 1'b0;
        if (push_n)
            push_wait <= 1'b0;
        // released bus shows a changing pattern
        if (pop_n)
            data_from_fifo <= ~data_from_fifo;
        if (!reset_pin_n)
        begin
            wptr <= '0;
            rptr <= '0;
            count <= 0;
            pushes <= 0;
            expanded <= expand_in_n;
            rd_turn <= !expand_in_n || !retransmit_n;
            data_from_fifo <= 9'h155;
        end
        else if (last_retx && !retransmit_n && !expanded)
        begin
            rptr <= '0;
            count <= (pushes < FIFO_DEPTH) ? pushes : FIFO_DEPTH;
        end
        else
        begin
            level = count;
            // expansion hands the read turn round the ring
            if (expanded && !expand_in_n)
                rd_turn <= 1'b1;
            // read at strobe fall, beside pushes
            if (last_pop && !pop_n && level > 0 && rd_turn)
            begin
                data_from_fifo <= mem[rptr];
                rptr <= rptr + 1'b1;
                level = level - 1;
                if (rptr == 9'(FIFO_DEPTH - 1))
                begin
                    edge_out <= 1'b0;
                    rd_turn <= !expanded;
                end
            end
            else if (last_pop && !pop_n && level == 0)
                pop_wait <= 1'b1;
            if (last_push && !push_n && level >= FIFO_DEPTH)
                push_wait <= 1'b1;
            // store at strobe rise when a location is free
            if (!last_push && push_n && level < FIFO_DEPTH)
            begin
                mem[wptr] <= data_to_fifo;
                wptr <= wptr + 1'b1;
                pushes <= pushes + 1;
                if (wptr == 9'(FIFO_DEPTH - 1))
                    edge_out <= 1'b0;
                // only the first word flows through a held pop
                if (pop_wait)
                begin
                    data_from_fifo <= data_to_fifo;
                    rptr <= rptr + 1'b1;
                    pop_wait <= 1'b0;
                end
                else
                    level = level + 1;
            end
            count <= level;
        end
    end
endmodule

// [test_afctl_top.sv]
// Self-checking bench for the FIFO host controller with a device model.
// Assumes the checker is bound into afctl_top by its own file.
`timescale 1ns/1ps
module test_afctl_top;
    import afctl_pkg::*;
    logic                  clk_sys, rstn, wr_valid, wr_ready, rd_valid, rd_ready;
    logic                  retx_req, retx_ack, retx_refused, fifo_empty, fifo_full;
    logic                  fifo_half, push_n, pop_n, empty_flag_n, full_flag_n;
    logic                  half_full_flag_n, retransmit_n, expand_in_n, reset_pin_n;
    logic [WORD_WIDTH-1:0] wr_data, rd_data, data_to_fifo, data_from_fifo;
    int                    num_errors = 0;
    int                    check_count = 0;
    afctl_top uut (.*);
    afctl_dev_model u_dev (.*);
    function automatic logic [WORD_WIDTH-1:0] wv(input int k);
        wv = WORD_WIDTH'(k * 37 + 5);
    endfunction
    task automatic check(input string what, input logic [WORD_WIDTH-1:0] exp, got);
        check_count++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            num_errors++;
        end
    endtask
    task automatic push_word(input logic [WORD_WIDTH-1:0] v, output logic ok);
        ok = 0;
        @(posedge clk_sys);
        wr_valid <= 1;
        wr_data <= v;
        for (int n = 0; n < 60 && !ok; n++)
        begin
            @(negedge clk_sys);
            ok = (wr_ready === 1'b1);
        end
        @(posedge clk_sys);
        wr_valid <= 0;
    endtask
    task automatic read_seq(input int cnt);
        logic ok;
        logic [WORD_WIDTH-1:0] v;
        for (int k = 0; k < cnt; k++)
        begin
            ok = 0;
            @(posedge clk_sys);
            rd_ready <= 1;
            for (int n = 0; n < 60 && !ok; n++)
            begin
                @(negedge clk_sys);
                ok = (rd_valid === 1'b1);
                v = rd_data;
            end
            @(posedge clk_sys);
            rd_ready <= 0;
            check("word", wv(k), v);
        end
    endtask
    task automatic rewind(input logic exp_ack);
        logic seen;
        seen = 0;
        @(posedge clk_sys);
        retx_req <= 1;
        for (int n = 0; n < 60 && !seen; n++)
        begin
            @(negedge clk_sys);
            seen = (retx_ack === 1'b1 || retx_refused === 1'b1);
        end
        check("rewind ack", exp_ack, retx_ack);
        check("rewind refused", !exp_ack, retx_refused);
        @(posedge clk_sys);
        retx_req <= 0;
    endtask
    task automatic t_order_rewind();
        logic ok;
        for (int k = 0; k < 3; k++)
            push_word(wv(k), ok);
        read_seq(3);
        check("empty", 1, fifo_empty);
        rewind(1);
        check("empty after rewind", 0, fifo_empty);
        read_seq(3);
        $display("test order and rewind done");
    endtask
    task automatic t_full();
        logic ok;
        int n;
        n = 0;
        do
        begin
            push_word(wv(n), ok);
            n += ok;
        end
        while (ok);
        check("full", 1, fifo_full);
        check("half", 1, fifo_half);
        check("held words", 1, n > FIFO_DEPTH);
        read_seq(n);
        check("empty", 1, fifo_empty);
        rewind(0);
        $display("test full and refusal done");
    endtask
    task automatic t_reset();
        @(posedge clk_sys);
        rstn <= 0;
        repeat (2) @(posedge clk_sys);
        check("reset pin", 0, reset_pin_n);
        check("empty in reset", 1, fifo_empty);
        rstn <= 1;
        rewind(1);
        check("empty after reset", 1, fifo_empty);
        $display("test mid-run reset done");
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        clk_sys = 0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial
    begin
        #400_000;
        num_errors++;
        end_of_test();
    end
    initial
    begin
        rstn = 0;
        wr_valid = 0;
        wr_data = '0;
        rd_ready = 0;
        retx_req = 0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1;
        t_order_rewind();
        t_full();
        t_reset();
        end_of_test();
    end
endmodule
